// ### aasp_pkg.sv
// package for the addressed attenuator serial port: payload layout, register map,
// reset values, link timing and the master's state encoding.
// assumes the master runs its own logic from a 40 ns system clock; devices may use their own clock.
`default_nettype none

package aasp_pkg;

    // payload layout, bit 0 is shifted first
    localparam int PAYLOAD_BITS  = 16;
    localparam int DATA_LSB      = 0;
    localparam int DATA_MSB      = 6;
    localparam int DATA_RSVD_BIT = 7;
    localparam int CHIP_ID_LSB   = 8;
    localparam int CHIP_ID_MSB   = 10;
    localparam int ADDR_RSVD_BIT = 11;
    localparam int REG_ADDR_LSB  = 12;
    localparam int REG_ADDR_MSB  = 15;

    // register addresses inside one device
    localparam logic [3:0] REG_SERIAL_ATTEN = 4'h0;
    localparam logic [3:0] REG_PRESET_CFG   = 4'h1;
    localparam logic [3:0] REG_PRESET_WORD  = 4'h2;

    // values after reset
    localparam logic [7:0] SERIAL_ATTEN_RST = 8'h7F;
    localparam logic [7:0] PRESET_CFG_RST   = 8'h00;
    localparam logic [7:0] PRESET_WORD_RST  = 8'h7F;

    // preset configuration bit positions
    localparam int CFG_POINTER_BIT = 0;
    localparam int CFG_ENABLE_BIT  = 1;

    // identifier seen when the three pins float
    localparam logic [2:0] ID_FLOAT_LEVEL = 3'h6;

    // timing, in ns and in system clock cycles (least times round up)
    localparam int SYS_CLK_NS    = 40;
    localparam int SCLK_HALF_NS  = 80;
    localparam int STB_SETUP_NS  = 80;
    localparam int STB_HIGH_NS   = 320;
    localparam int STB_GAP_NS    = 320;

    function automatic logic [7:0] ns_to_cycles(input int ns);
        int c;
        c = (ns + SYS_CLK_NS - 1) / SYS_CLK_NS;
        if (c < 1) begin
            c = 1;
        end
        return 8'(c);
    endfunction

    localparam logic [7:0] SCLK_HALF_CYC = ns_to_cycles(SCLK_HALF_NS);
    localparam logic [7:0] STB_SETUP_CYC = ns_to_cycles(STB_SETUP_NS);
    localparam logic [7:0] STB_HIGH_CYC  = ns_to_cycles(STB_HIGH_NS);
    localparam logic [7:0] STB_GAP_CYC   = ns_to_cycles(STB_GAP_NS);

    // master sequencer states
    typedef enum logic [2:0] {
        AASP_IDLE     = 3'b000,
        AASP_SETUP    = 3'b001,
        AASP_CLK_HIGH = 3'b010,
        AASP_CLK_LOW  = 3'b011,
        AASP_STROBE   = 3'b100,
        AASP_RELEASE  = 3'b101
    } aasp_state_e;

    // builds the 16-bit payload: data word low, address word high, reserved bits zero
    function automatic logic [15:0] aasp_payload(input logic [2:0] chip_id,
                                                 input logic [3:0] reg_addr,
                                                 input logic [6:0] data);
        return {reg_addr, 1'b0, chip_id, 1'b0, data};
    endfunction

endpackage

`default_nettype wire

// ### aasp_link_if.sv
// shared serial link between one master and up to eight attenuator devices.
// assumes the master alone drives every wire; devices only listen.
`default_nettype none

interface aasp_link_if;
    logic serial_clk;                 // serial clock, made by the master
    logic serial_data;                // serial data, lsb first
    logic latch_strobe;               // low while shifting, pulsed high to latch
    logic preset_attenuation_select;  // high selects the preset attenuation word

    modport master (
        output serial_clk,
        output serial_data,
        output latch_strobe,
        output preset_attenuation_select
    );

    modport device (
        input serial_clk,
        input serial_data,
        input latch_strobe,
        input preset_attenuation_select
    );
endinterface

`default_nettype wire

// ### aasp_device.sv
// attenuator end of the serial port: shift register on the serial clock,
// identifier check and register file on the system clock.
// assumes the serial clock only runs while latch_strobe is low and is still
// for at least four system clocks of latch_strobe high.
`default_nettype none

module aasp_device
    import aasp_pkg::*;
(
    input  wire logic        sys_clk,                  // system clock
    input  wire logic        rst,                      // asynchronous reset, active high
    aasp_link_if.device      link,                     // shared serial link
    input  wire logic        chip_select_bit_zero_pin, // identifier pin, bit 0
    input  wire logic        chip_select_bit_one_pin,  // identifier pin, bit 1
    input  wire logic        chip_select_bit_two_pin,  // identifier pin, bit 2
    input  wire logic [2:0]  id_pin_connected,         // per pin: 1 driven, 0 floating
    output logic      [6:0]  attenuation_word,         // word applied to the attenuator
    output logic      [7:0]  serial_atten_word,        // register 0x0
    output logic      [7:0]  preset_config,            // register 0x1
    output logic      [7:0]  preset_attenuation_word,  // register 0x2
    output logic      [2:0]  static_identifier,        // identifier seen on the pins
    output logic             reg_write_pulse,          // one cycle: a register was written
    output logic             payload_ignored_pulse     // one cycle: payload was not ours
);

    // serial domain
    logic [15:0] shift_reg;

    // system domain
    logic        stb_meta_reg;
    logic        stb_sync_reg;
    logic        stb_prev_reg;
    logic        psel_meta_reg;
    logic        psel_sync_reg;
    logic [2:0]  id_meta_reg;
    logic [2:0]  id_sync_reg;
    logic [2:0]  conn_meta_reg;
    logic [2:0]  conn_sync_reg;
    logic [2:0]  id_reg;
    logic [15:0] word_reg;
    logic        match_reg;
    logic [7:0]  serial_atten_reg;
    logic [7:0]  preset_cfg_reg;
    logic [7:0]  preset_word_reg;
    logic [6:0]  atten_reg;
    logic [6:0]  atten_next;
    logic        write_reg;
    logic        ignored_reg;
    logic [2:0]  id_pin_level;
    logic        stb_rise;
    logic        stb_fall;
    logic        preset_active;

    // resolves a pin to its pull level when nothing drives it
    function automatic logic pin_level(input logic driven, input logic level, input logic pull);
        return driven ? level : pull;
    endfunction

    // pin two is the msb; floating pins fall back to pull-up, pull-up, pull-down
    // resolved from the synchronised copies, so no logic sits ahead of the first flop
    assign id_pin_level[2] = pin_level(conn_sync_reg[2], id_sync_reg[2],
                                       ID_FLOAT_LEVEL[2]);
    assign id_pin_level[1] = pin_level(conn_sync_reg[1], id_sync_reg[1],
                                       ID_FLOAT_LEVEL[1]);
    assign id_pin_level[0] = pin_level(conn_sync_reg[0], id_sync_reg[0],
                                       ID_FLOAT_LEVEL[0]);

    // shift register on the link clock; bit 0 ends up holding the first bit sent
    always_ff @(posedge link.serial_clk or posedge rst) begin
        if (rst) begin
            shift_reg <= 16'h0000;
        end else if (!link.latch_strobe) begin
            shift_reg <= {link.serial_data, shift_reg[15:1]};
        end
    end

    // two-stage synchronisers for the strobe, the preset pin and the id straps
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stb_meta_reg  <= 1'b0;
            stb_sync_reg  <= 1'b0;
            stb_prev_reg  <= 1'b0;
            psel_meta_reg <= 1'b0;
            psel_sync_reg <= 1'b0;
            id_meta_reg   <= 3'h0;
            id_sync_reg   <= 3'h0;
            conn_meta_reg <= 3'h0;
            conn_sync_reg <= 3'h0;
        end else begin
            stb_meta_reg  <= link.latch_strobe;
            stb_sync_reg  <= stb_meta_reg;
            stb_prev_reg  <= stb_sync_reg;
            psel_meta_reg <= link.preset_attenuation_select;
            psel_sync_reg <= psel_meta_reg;
            id_meta_reg   <= {chip_select_bit_two_pin, chip_select_bit_one_pin, chip_select_bit_zero_pin};
            id_sync_reg   <= id_meta_reg;
            conn_meta_reg <= id_pin_connected;
            conn_sync_reg <= conn_meta_reg;
        end
    end

    // resolved identifier kept in a flop, so the compare and the output see a clean value
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            id_reg <= 3'h0;
        end else begin
            id_reg <= id_pin_level;
        end
    end

    assign stb_rise = stb_sync_reg & ~stb_prev_reg;
    assign stb_fall = ~stb_sync_reg & stb_prev_reg;

    // the shift register is frozen while the strobe is high (clock still), so the
    // word is safe to copy once the synchronised rise is seen
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            word_reg  <= 16'h0000;
            match_reg <= 1'b0;
        end else if (stb_rise) begin
            word_reg  <= shift_reg;
            match_reg <= (shift_reg[CHIP_ID_MSB:CHIP_ID_LSB] == id_reg);
        end else if (stb_fall) begin
            match_reg <= 1'b0;
        end
    end

    // register writes on the strobe fall; the reserved data bit is kept but never used
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            serial_atten_reg <= SERIAL_ATTEN_RST;
            preset_cfg_reg   <= PRESET_CFG_RST;
            preset_word_reg  <= PRESET_WORD_RST;
            write_reg        <= 1'b0;
            ignored_reg      <= 1'b0;
        end else begin
            write_reg   <= 1'b0;
            ignored_reg <= 1'b0;
            if (stb_fall && match_reg) begin
                write_reg <= 1'b1;
                case (word_reg[REG_ADDR_MSB:REG_ADDR_LSB])
                    REG_SERIAL_ATTEN: begin
                        serial_atten_reg <= word_reg[DATA_RSVD_BIT:DATA_LSB];
                    end
                    REG_PRESET_CFG: begin
                        preset_cfg_reg <= word_reg[DATA_RSVD_BIT:DATA_LSB];
                    end
                    REG_PRESET_WORD: begin
                        preset_word_reg <= word_reg[DATA_RSVD_BIT:DATA_LSB];
                    end
                    default: begin
                        // unused addresses hold nothing; a write to them is dropped
                        write_reg <= 1'b0;
                    end
                endcase
            end else if (stb_fall) begin
                ignored_reg <= 1'b1;
            end
        end
    end

    // preset takes effect only when both configuration bits are set and the pin is high;
    // the top bit of every stored word is excluded from the applied word
    assign preset_active = psel_sync_reg & preset_cfg_reg[CFG_ENABLE_BIT]
                           & preset_cfg_reg[CFG_POINTER_BIT];

    always_comb begin
        if (preset_active) begin
            atten_next = preset_word_reg[DATA_MSB:DATA_LSB];
        end else begin
            atten_next = serial_atten_reg[DATA_MSB:DATA_LSB];
        end
    end

    // applied word registered; the preset path costs the synchroniser delay plus this one register stage
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            atten_reg <= SERIAL_ATTEN_RST[DATA_MSB:DATA_LSB];
        end else begin
            atten_reg <= atten_next;
        end
    end

    // outputs, all from flip-flops
    assign attenuation_word        = atten_reg;
    assign serial_atten_word       = serial_atten_reg;
    assign preset_config           = preset_cfg_reg;
    assign preset_attenuation_word = preset_word_reg;
    assign static_identifier       = id_reg;
    assign reg_write_pulse         = write_reg;
    assign payload_ignored_pulse   = ignored_reg;

endmodule // aasp_device

`default_nettype wire

// ### aasp_master.sv
// serial master end: turns one user command into one 16-bit payload on the link,
// makes the serial clock by dividing the system clock.
// assumes the user holds cmd fields stable while cmd_valid is high and not taken.
`default_nettype none

module aasp_master
    import aasp_pkg::*;
(
    input  wire logic        sys_clk,       // system clock
    input  wire logic        rst,           // asynchronous reset, active high
    aasp_link_if.master      link,          // shared serial link
    input  wire logic        cmd_valid,     // a write is requested
    output logic             cmd_ready,     // master idle, request taken this edge
    input  wire logic [2:0]  cmd_chip_id,   // target device identifier
    input  wire logic [3:0]  cmd_reg_addr,  // target register address
    input  wire logic [6:0]  cmd_data,      // seven-bit value to write
    input  wire logic        preset_select, // level for the preset select pin
    output logic             cmd_done       // one cycle: transfer finished
);

    aasp_state_e state_reg;
    logic [7:0]  cnt_reg;
    logic [7:0]  limit;
    logic        phase_end;
    logic [4:0]  bit_reg;
    logic [15:0] shift_reg;
    logic        sclk_reg;
    logic        stb_reg;
    logic        psel_reg;
    logic        done_reg;

    assign cmd_ready = (state_reg == AASP_IDLE);

    // length of the current phase in system cycles
    always_comb begin
        case (state_reg)
            AASP_SETUP:    limit = STB_SETUP_CYC;
            AASP_CLK_HIGH: limit = SCLK_HALF_CYC;
            AASP_CLK_LOW:  limit = SCLK_HALF_CYC;
            AASP_STROBE:   limit = STB_HIGH_CYC;
            AASP_RELEASE:  limit = STB_GAP_CYC;
            default:       limit = 8'h01;
        endcase
    end

    assign phase_end = (cnt_reg == limit - 8'h01);

    // sequencer: one request, sixteen clocks, then strobe high and low again
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state_reg <= AASP_IDLE;
            cnt_reg   <= 8'h00;
            bit_reg   <= 5'h00;
            done_reg  <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            cnt_reg  <= phase_end ? 8'h00 : cnt_reg + 8'h01;
            case (state_reg)
                AASP_IDLE: begin
                    cnt_reg <= 8'h00;
                    bit_reg <= 5'h00;
                    if (cmd_valid) begin
                        state_reg <= AASP_SETUP;
                    end
                end
                AASP_SETUP: begin
                    if (phase_end) state_reg <= AASP_CLK_HIGH;
                end
                AASP_CLK_HIGH: begin
                    if (phase_end) begin
                        state_reg <= AASP_CLK_LOW;
                        bit_reg   <= bit_reg + 5'h01;
                    end
                end
                AASP_CLK_LOW: begin
                    if (phase_end) begin
                        state_reg <= (bit_reg == 5'(PAYLOAD_BITS)) ? AASP_STROBE : AASP_CLK_HIGH;
                    end
                end
                AASP_STROBE: begin
                    if (phase_end) state_reg <= AASP_RELEASE;
                end
                AASP_RELEASE: begin
                    if (phase_end) begin
                        state_reg <= AASP_IDLE;
                        done_reg  <= 1'b1;
                    end
                end
                default: begin
                    state_reg <= AASP_IDLE;
                end
            endcase
        end
    end

    // payload shifter; data moves on the falling clock so the device samples mid-bit
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            shift_reg <= 16'h0000;
        end else if (state_reg == AASP_IDLE && cmd_valid) begin
            shift_reg <= aasp_payload(cmd_chip_id, cmd_reg_addr, cmd_data);
        end else if (state_reg == AASP_CLK_HIGH && phase_end) begin
            shift_reg <= {1'b0, shift_reg[15:1]};
        end
    end

    // link pins, all registered; clock stands still outside the shifting phases
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sclk_reg <= 1'b0;
            stb_reg  <= 1'b0;
            psel_reg <= 1'b0;
        end else begin
            sclk_reg <= (state_reg == AASP_SETUP && phase_end) ||
                        (state_reg == AASP_CLK_LOW && phase_end && bit_reg != 5'(PAYLOAD_BITS)) ||
                        (state_reg == AASP_CLK_HIGH && !phase_end);
            stb_reg  <= (state_reg == AASP_CLK_LOW && phase_end && bit_reg == 5'(PAYLOAD_BITS)) ||
                        (state_reg == AASP_STROBE && !phase_end);
            psel_reg <= preset_select;
        end
    end

    assign link.serial_clk                = sclk_reg;
    assign link.serial_data               = shift_reg[0];
    assign link.latch_strobe              = stb_reg;
    assign link.preset_attenuation_select = psel_reg;
    assign cmd_done                       = done_reg;

endmodule // aasp_master

`default_nettype wire

// ### aasp_link_props.sv
// checker for the shared serial link between the master and its devices.
// assumes the master alone drives every link wire from sys_clk.
`default_nettype none

module aasp_link_props (
    input wire logic sys_clk,      // master clock
    input wire logic rst,          // asynchronous reset, active high
    input wire logic serial_clk,   // link clock
    input wire logic serial_data,  // link data
    input wire logic latch_strobe  // latch strobe
);
    timeunit 1ns;
    timeprecision 1ps;

    logic        clk_q;
    logic        stb_q;
    logic [4:0]  rises;
    logic [15:0] sh;

    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);

    // one cycle of history on the two link wires that frame a transfer
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk_q <= 1'b0;
            stb_q <= 1'b0;
        end else begin
            clk_q <= serial_clk;
            stb_q <= latch_strobe;
        end
    end

    // clock rises of one frame; cleared as the strobe falls, so each frame starts at zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            rises <= 5'h00;
        end else if (stb_q && !latch_strobe) begin
            rises <= 5'h00;
        end else if (serial_clk && !clk_q) begin
            rises <= rises + 5'h01;
        end
    end

    // payload as a device shifts it in, lsb first
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sh <= 16'h0000;
        end else if (serial_clk && !clk_q) begin
            sh <= {serial_data, sh[15:1]};
        end
    end

    property p_clk_still;
        latch_strobe |-> !serial_clk;
    endproperty
    a_clk_still: assert property (p_clk_still)
        else $error("serial clock high while strobe high");

    property p_strobe_width;
        $rose(latch_strobe) |-> latch_strobe[*8] ##1 !latch_strobe;
    endproperty
    a_strobe_width: assert property (p_strobe_width)
        else $error("strobe pulse width wrong");

    property p_strobe_gap;
        $fell(latch_strobe) |-> !latch_strobe[*8];
    endproperty
    a_strobe_gap: assert property (p_strobe_gap)
        else $error("strobe low gap too short");

    property p_bit_count;
        $rose(latch_strobe) |-> rises == 5'h10;
    endproperty
    a_bit_count: assert property (p_bit_count)
        else $error("frame does not hold sixteen clock rises");

    property p_addr_rsvd;
        $rose(latch_strobe) |-> sh[11] == 1'b0;
    endproperty
    a_addr_rsvd: assert property (p_addr_rsvd)
        else $error("reserved address bit sent as one");

    property p_clk_high;
        $rose(serial_clk) |-> serial_clk[*2] ##1 !serial_clk;
    endproperty
    a_clk_high: assert property (p_clk_high)
        else $error("serial clock high phase wrong");

    property p_clk_low;
        $fell(serial_clk) |-> !serial_clk[*2];
    endproperty
    a_clk_low: assert property (p_clk_low)
        else $error("serial clock low phase too short");

    property p_data_stable;
        (serial_clk || $rose(serial_clk)) |-> $stable(serial_data);
    endproperty
    a_data_stable: assert property (p_data_stable)
        else $error("serial data moved around a clock rise");

endmodule // aasp_link_props

`default_nettype wire

// ### testbench.sv
// top bench: one master and two devices on one link, checker beside the link.
// assumes a 40 ns master clock and an unrelated 30 ns device clock.
`default_nettype none

module testbench
    import aasp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        sys_clk, dev_clk, rst, cmd_valid, cmd_ready, cmd_done, preset_select;
    logic [2:0]  cmd_chip_id, id_a, conn_b, idb, sid_a, sid_b;
    logic [3:0]  cmd_reg_addr;
    logic [6:0]  cmd_data, att_a, att_b;
    logic [7:0]  ra [3];
    logic [7:0]  rb [3];
    logic [7:0]  ea [3];
    logic [7:0]  eb [3];
    logic        wp_a, wp_b, ip_a, ip_b;
    logic [15:0] cap;
    int          miscompares, checks, nwa, nwb, nia, nib, ewa, ewb, eia, eib;

    aasp_link_if link ();

    aasp_master i_aasp_master (.sys_clk(sys_clk), .rst(rst), .link(link), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .cmd_chip_id(cmd_chip_id), .cmd_reg_addr(cmd_reg_addr),
        .cmd_data(cmd_data), .preset_select(preset_select), .cmd_done(cmd_done));
    aasp_device i_aasp_device (.sys_clk(dev_clk), .rst(rst), .link(link), .chip_select_bit_zero_pin(id_a[0]),
        .chip_select_bit_one_pin(id_a[1]), .chip_select_bit_two_pin(id_a[2]), .id_pin_connected(3'h7),
        .attenuation_word(att_a), .serial_atten_word(ra[0]), .preset_config(ra[1]),
        .preset_attenuation_word(ra[2]), .static_identifier(sid_a), .reg_write_pulse(wp_a),
        .payload_ignored_pulse(ip_a));
    aasp_device i_aasp_device_b (.sys_clk(dev_clk), .rst(rst), .link(link), .chip_select_bit_zero_pin(id_a[0]),
        .chip_select_bit_one_pin(id_a[1]), .chip_select_bit_two_pin(id_a[2]), .id_pin_connected(conn_b),
        .attenuation_word(att_b), .serial_atten_word(rb[0]), .preset_config(rb[1]),
        .preset_attenuation_word(rb[2]), .static_identifier(sid_b), .reg_write_pulse(wp_b),
        .payload_ignored_pulse(ip_b));
    aasp_link_props i_aasp_link_props (.sys_clk(sys_clk), .rst(rst), .serial_clk(link.serial_clk),
        .serial_data(link.serial_data), .latch_strobe(link.latch_strobe));

    // clocks: device clock offset so the two never share edges
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    initial begin
        dev_clk = 1'b0;
        #7;
        forever #15 dev_clk = ~dev_clk;
    end

    // one-cycle pulses are counted where they live, in the device clock
    always @(posedge dev_clk) begin
        if (wp_a === 1'b1) nwa++;
        if (wp_b === 1'b1) nwb++;
        if (ip_a === 1'b1) nia++;
        if (ip_b === 1'b1) nib++;
    end

    // the bench's own reading of the wire, lsb first
    always @(posedge link.serial_clk) begin
        if (link.latch_strobe === 1'b0) cap <= {link.serial_data, cap[15:1]};
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // registers, applied word and pulse counts against the bench's model
    task automatic chk_all();
        for (int i = 0; i < 3; i++) begin
            chk(16'(ra[i]), 16'(ea[i]));
            chk(16'(rb[i]), 16'(eb[i]));
        end
        chk(16'(att_a), (preset_select && ea[1][1:0] == 2'b11) ? 16'(ea[2][6:0]) : 16'(ea[0][6:0]));
        chk(16'(att_b), (preset_select && eb[1][1:0] == 2'b11) ? 16'(eb[2][6:0]) : 16'(eb[0][6:0]));
        chk(16'(nwa), 16'(ewa));
        chk(16'(nwb), 16'(ewb));
        chk(16'(nia), 16'(eia));
        chk(16'(nib), 16'(eib));
    endtask

    // one write through the master; the bounded waits end the run on a hang
    task automatic wr(input logic [2:0] id, input logic [3:0] ad, input logic [6:0] d);
        int n;
        n = 0;
        @(posedge sys_clk);
        cmd_chip_id  <= id;
        cmd_reg_addr <= ad;
        cmd_data     <= d;
        cmd_valid    <= 1'b1;
        @(negedge sys_clk);
        while (cmd_ready !== 1'b1 && n < 200) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        while (cmd_done !== 1'b1 && n < 400) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= 400) begin
            miscompares++;
            close_out();
        end
        repeat (4) @(posedge sys_clk);
        chk(16'(cmd_ready), 16'h0001);
        chk(cap, {ad, 1'b0, id, 1'b0, d});
        if (ad < 4'h3 && id === id_a) ea[ad] = {1'b0, d};
        if (ad < 4'h3 && id === idb) eb[ad] = {1'b0, d};
        if (id === id_a && ad < 4'h3) ewa++;
        if (id === idb && ad < 4'h3) ewb++;
        if (id !== id_a) eia++;
        if (id !== idb) eib++;
        chk_all();
    endtask

    // preset select level, then a settle time covering pin, sync and output stages
    task automatic ps(input logic v);
        @(posedge sys_clk);
        preset_select <= v;
        repeat (6) @(posedge sys_clk);
        chk_all();
    endtask

    initial begin
        rst           = 1'b1;
        cmd_valid     = 1'b0;
        cmd_chip_id   = 3'h0;
        cmd_reg_addr  = 4'h0;
        cmd_data      = 7'h00;
        preset_select = 1'b0;
        id_a          = 3'h5;
        conn_b        = 3'h0;
        idb           = 3'h6;
        cap           = 16'h0000;
        ea            = '{SERIAL_ATTEN_RST, PRESET_CFG_RST, PRESET_WORD_RST};
        eb            = '{SERIAL_ATTEN_RST, PRESET_CFG_RST, PRESET_WORD_RST};
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        chk_all();
        chk(16'(sid_a), 16'h0005);
        chk(16'(sid_b), 16'h0006);
        $display("test reset done");
        // every identifier in turn: only the owner of each one takes the write
        for (int i = 0; i < 8; i++) begin
            wr(3'(i), REG_SERIAL_ATTEN, 7'(17 * i + 5));
        end
        $display("test identifiers done");
        // each register, then unused addresses that must change nothing
        for (int a = 0; a < 4; a++) begin
            wr(3'h5, 4'(a), 7'(124 + a));
        end
        wr(3'h5, 4'hF, 7'h55);
        $display("test register map done");
        // preset pin with the pointer bit only, with both config bits, and with enable only
        wr(3'h5, REG_PRESET_WORD, 7'h2A);
        ps(1'b1);
        wr(3'h5, REG_PRESET_CFG, 7'h03);
        ps(1'b0);
        ps(1'b1);
        wr(3'h5, REG_PRESET_CFG, 7'h02);
        ps(1'b0);
        $display("test preset done");
        // grounded pins on both devices: both now answer to zero
        @(posedge sys_clk);
        id_a   <= 3'h0;
        conn_b <= 3'h7;
        idb    <= 3'h0;
        repeat (6) @(posedge sys_clk);
        chk(16'(sid_a), 16'h0000);
        chk(16'(sid_b), 16'h0000);
        wr(3'h0, REG_SERIAL_ATTEN, 7'h33);
        $display("test grounded id done");
        close_out();
    end

endmodule // testbench

`default_nettype wire
